// [hw/acc_top.sv]
// Comparator control and status logic with APB register access
//
// Function
// - result high when positive above negative
// - result synchronised, two cycles behind compare
// - mode field picks toggle, fall, rise
// - chosen edge sets event flag
// - flag clears on vector or written one
// - interrupt needs flag, enable, mask bit, global enable
// - disable bit switches comparator off
// - reference select feeds bandgap to positive
// - reserved bit two reads zero
// - mux enable routes converter pin negative
// - buffer off bit forces pin zero
// - converter on blocks multiplexer borrowing
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "acc_regs.svh"

module acc_top #(
    parameter int AW = 10
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    // Analog levels, sampled as words
    input  wire logic [AW-1:0] positive_input_pin,
    input  wire logic [AW-1:0] negative_input_pin,
    input  wire logic [AW-1:0] bandgap_level,
    input  wire logic [AW-1:0] converter_input_pins [4],
    // Digital side of the comparator pins
    input  wire logic          pos_pin_digital,
    input  wire logic          neg_pin_digital,
    output logic [1:0]         port_pin_value,
    output logic [1:0]         pin_buffer_off,
    // Interrupt system
    input  wire logic          global_irq_enable,
    input  wire logic          vector_taken,
    output logic               compare_irq,
    // Status
    output logic               compare_result,
    output logic               comparator_off
);

    ////////////////////////////////////////////////////////////////////////////
    acc_pkg::acc_state_t q;
    acc_pkg::acc_state_t d;
    logic          raw_cmp;
    logic [AW-1:0] pos_level;
    logic [AW-1:0] neg_level;
    logic          neg_from_mux;
    logic          event_pulse;
    logic          rd_setup;
    logic          wr_done;
    logic          addr_ok;
    logic          w1c_flag;
    logic [31:0]   rd_word;

    function automatic logic known_addr(input logic [11:0] a);
        unique case (a)
            `ACC_OFF_CSR, `ACC_OFF_CONV_B, `ACC_OFF_DIDR, `ACC_OFF_CHAN,
            `ACC_OFF_CONV_A, `ACC_OFF_IRQ_STAT, `ACC_OFF_IRQ_MASK: known_addr = 1'b1;
            default: known_addr = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input selection and compare
    // Multiplexer only borrowed while the converter is off
    assign neg_from_mux = q.mux_en && !q.conv_on;
    assign neg_level    = neg_from_mux ? converter_input_pins[q.chan]
                                       : negative_input_pin;
    assign pos_level    = q.refsel ? bandgap_level : positive_input_pin;
    // Powered-down comparator rests low
    assign raw_cmp      = !q.off && (pos_level > neg_level);

    // Edge selection on the synchronised result
    always_comb begin
        unique case (q.mode)
            `ACC_MODE_TOGGLE: event_pulse = q.sync2 != q.prev;
            `ACC_MODE_FALL:   event_pulse = q.prev && !q.sync2;
            `ACC_MODE_RISE:   event_pulse = !q.prev && q.sync2;
            default:          event_pulse = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign addr_ok  = known_addr(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_done  = psel && penable && pwrite && addr_ok && pstrb[0];
    assign w1c_flag = wr_done && pwdata[`ACC_CSR_FLAG]
                      && (paddr == `ACC_OFF_CSR || paddr == `ACC_OFF_IRQ_STAT);

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (paddr)
            `ACC_OFF_CSR: begin
                rd_word[`ACC_CSR_OFF]     = q.off;
                rd_word[`ACC_CSR_REFSEL]  = q.refsel;
                rd_word[`ACC_CSR_RESULT]  = q.sync2;
                rd_word[`ACC_CSR_FLAG]    = q.flag;
                rd_word[`ACC_CSR_IE]      = q.ie;
                rd_word[`ACC_CSR_RSVD]    = 1'b0;
                rd_word[`ACC_CSR_MODE_HI] = q.mode[1];
                rd_word[`ACC_CSR_MODE_LO] = q.mode[0];
            end
            `ACC_OFF_CONV_B:   rd_word[`ACC_CONVB_MUXEN] = q.mux_en;
            `ACC_OFF_DIDR:     rd_word[1:0] = q.buf_off;
            `ACC_OFF_CHAN:     rd_word[1:0] = q.chan;
            `ACC_OFF_CONV_A:   rd_word[`ACC_CONVA_ON] = q.conv_on;
            `ACC_OFF_IRQ_STAT: rd_word[`ACC_CSR_FLAG] = q.flag;
            `ACC_OFF_IRQ_MASK: rd_word[`ACC_CSR_FLAG] = q.mask;
            default:           rd_word = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d = q;
        // Two stages; first stage feeds only the second
        d.sync1 = raw_cmp;
        d.sync2 = q.sync1;
        d.prev  = q.sync2;
        // Set wins over either clear so no edge is lost
        if (event_pulse) begin
            d.flag = 1'b1;
        end else if (vector_taken || w1c_flag) begin
            d.flag = 1'b0;
        end
        if (wr_done) begin
            unique case (paddr)
                `ACC_OFF_CSR: begin
                    d.off    = pwdata[`ACC_CSR_OFF];
                    d.refsel = pwdata[`ACC_CSR_REFSEL];
                    d.ie     = pwdata[`ACC_CSR_IE];
                    d.mode   = pwdata[`ACC_CSR_MODE_HI:`ACC_CSR_MODE_LO];
                end
                `ACC_OFF_CONV_B:   d.mux_en  = pwdata[`ACC_CONVB_MUXEN];
                `ACC_OFF_DIDR:     d.buf_off = pwdata[1:0];
                `ACC_OFF_CHAN:     d.chan    = pwdata[1:0];
                `ACC_OFF_CONV_A:   d.conv_on = pwdata[`ACC_CONVA_ON];
                `ACC_OFF_IRQ_MASK: d.mask    = pwdata[`ACC_CSR_FLAG];
                default:           d.mask    = q.mask;
            endcase
        end
        // Read data captured in setup, so access phase never waits
        if (rd_setup) begin
            d.prdata = rd_word;
        end
        d.pin_val[`ACC_DIDR_POS] = pos_pin_digital && !q.buf_off[`ACC_DIDR_POS];
        d.pin_val[`ACC_DIDR_NEG] = neg_pin_digital && !q.buf_off[`ACC_DIDR_NEG];
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign pready         = 1'b1;
    assign pslverr        = psel && penable && !addr_ok;
    assign prdata         = q.prdata;
    // Flag stays visible while masked; only the line is gated
    assign compare_irq    = q.flag && q.ie && global_irq_enable && q.mask;
    assign compare_result = q.sync2;
    assign comparator_off = q.off;
    assign port_pin_value = q.pin_val;
    assign pin_buffer_off = q.buf_off;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence csr_write_s;
        psel && penable && pwrite && paddr == `ACC_OFF_CSR && pstrb[0];
    endsequence

    sequence off_held_s;
        q.off [*3];
    endsequence

    result_sync_a: assert property (
        rstn [*3] |-> compare_result == $past(raw_cmp, 2))
        else $error("result does not follow compare after two cycles");

    off_low_a: assert property (off_held_s |-> !compare_result)
        else $error("result high while comparator off");

    raw_cmp_a: assert property (
        !q.off && q.refsel && bandgap_level <= neg_level |-> !raw_cmp)
        else $error("compare high with reference not above negative");

    mux_route_a: assert property (
        q.conv_on |-> neg_level == negative_input_pin)
        else $error("multiplexer borrowed while converter on");

    reserved_mode_a: assert property (q.mode == `ACC_MODE_RSVD |-> !event_pulse)
        else $error("event in reserved mode");

    rise_event_a: assert property (
        q.mode == `ACC_MODE_RISE && $rose(q.sync2) |-> event_pulse)
        else $error("rising edge missed");

    flag_set_a: assert property (event_pulse |=> q.flag)
        else $error("flag not set by event");

    flag_clear_a: assert property (
        (((csr_write_s and pwdata[`ACC_CSR_FLAG]) or vector_taken) and !event_pulse)
        |=> !q.flag)
        else $error("flag not cleared");

    flag_keep_a: assert property (
        q.flag && !vector_taken && !w1c_flag |=> q.flag)
        else $error("flag lost without clear");

    irq_gate_a: assert property (!q.ie || !global_irq_enable |-> !compare_irq)
        else $error("interrupt raised while disabled");

    rsvd_read_a: assert property (
        rd_setup && paddr == `ACC_OFF_CSR |=> !prdata[`ACC_CSR_RSVD])
        else $error("reserved bit read as one");

    pin_off_a: assert property (
        q.buf_off[`ACC_DIDR_POS] ##1 q.buf_off[`ACC_DIDR_POS]
        |-> !port_pin_value[`ACC_DIDR_POS])
        else $error("pin reads one with buffer off");

    ////////////////////////////////////////////////////////////////////////////
    // Further checks on events, clears and routing
    // Edge checks watch the synchronised value only; the raw compare may glitch
    sequence stat_write_s;
        psel && penable && pwrite && paddr == `ACC_OFF_IRQ_STAT && pstrb[0];
    endsequence

    sequence neg_off_held_s;
        q.buf_off[`ACC_DIDR_NEG] ##1 q.buf_off[`ACC_DIDR_NEG];
    endsequence

    sequence pos_on_held_s;
        !q.buf_off[`ACC_DIDR_POS] ##1 !q.buf_off[`ACC_DIDR_POS];
    endsequence

    fall_event_a: assert property (
        q.mode == `ACC_MODE_FALL && $fell(q.sync2) |-> event_pulse)
        else $error("falling edge missed");

    toggle_event_a: assert property (
        q.mode == `ACC_MODE_TOGGLE && $changed(q.sync2) |-> event_pulse)
        else $error("toggle missed");

    no_edge_a: assert property ($stable(q.sync2) |-> !event_pulse)
        else $error("event without an edge");

    rise_only_a: assert property (
        q.mode == `ACC_MODE_RISE && !q.sync2 |-> !event_pulse)
        else $error("event on falling edge in rise mode");

    fall_only_a: assert property (
        q.mode == `ACC_MODE_FALL && q.sync2 |-> !event_pulse)
        else $error("event on rising edge in fall mode");

    flag_wins_a: assert property (
        event_pulse && (vector_taken || w1c_flag) |=> q.flag)
        else $error("clear beat a same-cycle event");

    stat_clear_a: assert property (
        (stat_write_s and pwdata[`ACC_CSR_FLAG] && !event_pulse) |=> !q.flag)
        else $error("flag not cleared through status word");

    vector_clear_a: assert property (
        vector_taken && !event_pulse |=> !q.flag)
        else $error("flag kept after vector taken");

    zero_write_a: assert property (
        (csr_write_s and q.flag && !pwdata[`ACC_CSR_FLAG] && !vector_taken) |=> q.flag)
        else $error("writing zero cleared the flag");

    irq_on_a: assert property (
        q.flag && q.ie && global_irq_enable && q.mask |-> compare_irq)
        else $error("interrupt not raised");

    irq_flag_a: assert property (!q.flag |-> !compare_irq)
        else $error("interrupt without flag");

    ie_block_a: assert property (
        (csr_write_s and !pwdata[`ACC_CSR_IE]) |=> !compare_irq)
        else $error("interrupt raised after enable cleared");

    off_set_a: assert property (
        (csr_write_s and pwdata[`ACC_CSR_OFF]) |=> comparator_off)
        else $error("disable bit not set by write");

    off_clear_a: assert property (
        (csr_write_s and !pwdata[`ACC_CSR_OFF]) |=> !comparator_off)
        else $error("disable bit not cleared by write");

    cmp_high_a: assert property (
        !q.off && !q.refsel && !neg_from_mux
        && positive_input_pin > negative_input_pin |-> raw_cmp)
        else $error("compare low with positive above negative");

    pos_pin_a: assert property (!q.refsel |-> pos_level == positive_input_pin)
        else $error("positive pin not selected");

    pos_ref_a: assert property (q.refsel |-> pos_level == bandgap_level)
        else $error("bandgap not selected");

    neg_pin_a: assert property (!q.mux_en |-> neg_level == negative_input_pin)
        else $error("negative pin not selected");

    mux_pick_a: assert property (
        q.mux_en && !q.conv_on |-> neg_level == converter_input_pins[q.chan])
        else $error("wrong converter pin routed");

    conv_block_a: assert property (q.conv_on |-> !neg_from_mux)
        else $error("converter on yet multiplexer selected");

    neg_off_a: assert property (neg_off_held_s |-> !port_pin_value[`ACC_DIDR_NEG])
        else $error("negative pin reads one with buffer off");

    pos_pass_a: assert property (
        pos_on_held_s |-> port_pin_value[`ACC_DIDR_POS] == $past(pos_pin_digital))
        else $error("positive pin value not passed");

endmodule

// [hw/acc_regs.svh]
// Register offsets, field positions and reset values of the comparator control block
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
`define ACC_OFF_CSR      12'h000
`define ACC_OFF_CONV_B   12'h004
`define ACC_OFF_DIDR     12'h008
`define ACC_OFF_CHAN     12'h00C
`define ACC_OFF_CONV_A   12'h010
`define ACC_OFF_IRQ_STAT 12'h014
`define ACC_OFF_IRQ_MASK 12'h018
`define ACC_CSR_MODE_LO  0
`define ACC_CSR_MODE_HI  1
`define ACC_CSR_RSVD     2
`define ACC_CSR_IE       3
`define ACC_CSR_FLAG     4
`define ACC_CSR_RESULT   5
`define ACC_CSR_REFSEL   6
`define ACC_CSR_OFF      7
`define ACC_CONVB_MUXEN  6
`define ACC_CONVA_ON     7
`define ACC_DIDR_POS     0
`define ACC_DIDR_NEG     1
`define ACC_CSR_RESET    8'h00
`define ACC_DIDR_RESET   2'h0
`define ACC_MODE_TOGGLE  2'h0
`define ACC_MODE_RSVD    2'h1
`define ACC_MODE_FALL    2'h2
`define ACC_MODE_RISE    2'h3
`define ACC_SYNC_STAGES  2
`endif

// [hw/acc_pkg.sv]
// Types of the comparator control block
package acc_pkg;
    typedef struct packed {
        logic        sync1;
        logic        sync2;
        logic        prev;
        logic        off;
        logic        refsel;
        logic        flag;
        logic        ie;
        logic [1:0]  mode;
        logic        mux_en;
        logic [1:0]  buf_off;
        logic        conv_on;
        logic [1:0]  chan;
        logic        mask;
        logic [31:0] prdata;
        logic [1:0]  pin_val;
    } acc_state_t;
endpackage

// [tb/acc_far_model.sv]
// Interrupt system model standing at the far side of the comparator block
`timescale 1ns/1ps

module acc_far_model (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Interrupt system
    input  wire logic compare_irq,
    input  wire logic service_on,
    output logic      vector_taken
);
    logic [1:0] wait_q;

    ////////////////////////////////////////////////////////////////////////
    // A CPU needs a few cycles before it runs the vector
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wait_q       <= 2'h0;
            vector_taken <= 1'b0;
        end else if (vector_taken) begin
            vector_taken <= 1'b0;
            wait_q       <= 2'h0;
        end else if (compare_irq && service_on) begin
            vector_taken <= (wait_q == 2'h2);
            wait_q       <= (wait_q == 2'h2) ? 2'h0 : wait_q + 2'h1;
        end else begin
            wait_q <= 2'h0;
        end
    end
endmodule

// [tb/acc_top_bench.sv]
// Self-checking bench of the comparator control block
`timescale 1ns/1ps
`include "acc_regs.svh"

module acc_top_bench;
    logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0]  pstrb;
    logic [9:0]  pos, neg, bg, p, n;
    logic [9:0]  cpins [4];
    logic        pos_dig, neg_dig, glob, service_on, vector_taken;
    logic [1:0]  port_pin_value, pin_buffer_off;
    logic        compare_irq, compare_result, comparator_off;
    logic [1:0]  modes [4] = '{`ACC_MODE_TOGGLE, `ACC_MODE_FALL, `ACC_MODE_RISE, `ACC_MODE_RSVD};
    int          errors, checks;
    int          cyc = 0;

    acc_top #(.AW(10)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .positive_input_pin(pos), .negative_input_pin(neg),
        .bandgap_level(bg), .converter_input_pins(cpins), .pos_pin_digital(pos_dig),
        .neg_pin_digital(neg_dig), .port_pin_value(port_pin_value),
        .pin_buffer_off(pin_buffer_off), .global_irq_enable(glob), .vector_taken(vector_taken),
        .compare_irq(compare_irq), .compare_result(compare_result),
        .comparator_off(comparator_off));
    acc_far_model far_u (.clk_sys(clk_sys), .rstn(rstn), .compare_irq(compare_irq),
        .service_on(service_on), .vector_taken(vector_taken));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [9:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[9:0];
    endfunction
    function automatic logic fires(input logic [1:0] m, input logic rise);
        return (m == `ACC_MODE_TOGGLE) || (rise ? m == `ACC_MODE_RISE : m == `ACC_MODE_FALL);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    // Held until pready is seen high; no wait-state count assumed
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic set_lv(input logic [9:0] a, input logic [9:0] b);
        @(posedge clk_sys);
        pos <= a; neg <= b;
        tick(4);
    endtask
    task automatic report_and_stop();
        if (errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            errors++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, glob, service_on, rstn} = 6'h00;
        paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hF; bg = 10'h000;
        pos = 10'h000; neg = 10'h200; cpins = '{default: 10'h3FF};
        pos_dig = 1'b1; neg_dig = 1'b1; seed = 32'hF8E3; errors = 0; checks = 0;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        apb(0, `ACC_OFF_CSR, 0); chk("csr reset", 0, rd);
        apb(0, `ACC_OFF_DIDR, 0); chk("didr reset", 0, rd);
        apb(1, `ACC_OFF_CSR, 32'h04); apb(0, `ACC_OFF_CSR, 0); chk("rsvd bit", 0, rd);
        apb(0, 12'h01C, 0); chk("unmapped err", 1, err);
        repeat (40) begin
            p = rnd(); n = rnd();
            @(posedge clk_sys); pos <= p; neg <= n;
            tick(2); chk("result", p > n, compare_result);
        end
        apb(0, `ACC_OFF_CSR, 0); chk("csr result", p > n, rd[5]);
        set_lv(10'h155, 10'h155); chk("equal", 0, compare_result);
        for (int i = 0; i < 4; i++) begin
            set_lv(10'h000, 10'h200);
            apb(1, `ACC_OFF_CSR, 32'h10 | modes[i]);
            set_lv(10'h300, 10'h200);
            apb(0, `ACC_OFF_CSR, 0); chk("rise flag", fires(modes[i], 1), rd[4]);
            apb(1, `ACC_OFF_CSR, 32'h10 | modes[i]);
            set_lv(10'h000, 10'h200);
            apb(0, `ACC_OFF_CSR, 0); chk("fall flag", fires(modes[i], 0), rd[4]);
        end
        apb(1, `ACC_OFF_CSR, 32'h13); set_lv(10'h300, 10'h200);
        apb(1, `ACC_OFF_CSR, 32'h03); apb(0, `ACC_OFF_CSR, 0); chk("flag kept", 1, rd[4]);
        apb(1, `ACC_OFF_IRQ_MASK, 32'h10);
        @(posedge clk_sys); glob <= 1'b1;
        apb(1, `ACC_OFF_CSR, 32'h0B); tick(1); chk("irq on", 1, compare_irq);
        apb(1, `ACC_OFF_IRQ_MASK, 32'h0); tick(1); chk("irq masked", 0, compare_irq);
        apb(1, `ACC_OFF_IRQ_MASK, 32'h10);
        apb(1, `ACC_OFF_CSR, 32'h03); tick(1); chk("irq ie off", 0, compare_irq);
        apb(1, `ACC_OFF_CSR, 32'h0B);
        @(posedge clk_sys); glob <= 1'b0;
        tick(1); chk("irq glob off", 0, compare_irq);
        @(posedge clk_sys); glob <= 1'b1; service_on <= 1'b1;
        tick(8); chk("irq served", 0, compare_irq);
        apb(0, `ACC_OFF_IRQ_STAT, 0); chk("stat flag", 0, rd[4]);
        @(posedge clk_sys); service_on <= 1'b0;
        apb(1, `ACC_OFF_CSR, 32'h03);
        apb(1, `ACC_OFF_CSR, 32'h83); tick(3);
        chk("off", 1, comparator_off); chk("off result", 0, compare_result);
        apb(1, `ACC_OFF_CSR, 32'h13);
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_sys);
            foreach (cpins[k]) cpins[k] <= (k == c) ? 10'h100 : 10'h3FF;
            pos <= 10'h200; neg <= 10'h3FF;
            apb(1, `ACC_OFF_CHAN, c); apb(1, `ACC_OFF_CONV_B, 32'h40);
            tick(3); chk("mux", 1, compare_result);
        end
        apb(1, `ACC_OFF_CONV_A, 32'h80); tick(3); chk("conv on", 0, compare_result);
        set_lv(10'h000, 10'h100);
        @(posedge clk_sys); bg <= 10'h200;
        apb(1, `ACC_OFF_CSR, 32'h40); tick(4); chk("bandgap hi", 1, compare_result);
        @(posedge clk_sys); bg <= 10'h080;
        tick(3); chk("bandgap lo", 0, compare_result);
        apb(0, `ACC_OFF_IRQ_STAT, 0); chk("stat set", 1, rd[4]);
        apb(1, `ACC_OFF_IRQ_STAT, 32'h10); apb(0, `ACC_OFF_IRQ_STAT, 0);
        chk("stat w1c", 0, rd[4]);
        for (int v = 0; v < 4; v++) begin
            @(posedge clk_sys); pos_dig <= rnd() > 10'h1FF; neg_dig <= 1'b1;
            apb(1, `ACC_OFF_DIDR, v); tick(2);
            chk("pin value", ~v[1:0] & {neg_dig, pos_dig}, port_pin_value);
            chk("buffer off", v[1:0], pin_buffer_off);
        end
        report_and_stop();
    end
endmodule
